/* shared/spi_port_map.vh */
// constants for the configurable serial peripheral port
// Function
// - separate two-byte transmit and receive FIFOs
// - drive on programmed edge, capture opposite
// - one bit out, one in, each clock
// - after last bit of a segment store byte, reload
// - keep controls cleared: discard rx, dummy tx
// - segment width programmable one to eight
// - master idles clock, deselects when done
// - unselected slave ignores bus, drives data only under direction control
// - master drives clock, slave receives it
// - polarity sets clock idle level
// - separate polarity for input, output, select
// - sample phase: middle or end
// - clock edge: first or second
// - rate divider applies only as master
// - bit order and select mode selectable
// - full, rx-only, tx-only, counted modes
// - enable activates port pins; clock and select drive only as master
// - disable aborts, blocks flags, empties FIFOs
// - direction control forces data out while enabled
// - tx bit routed to pin and peripherals
// - busy while master transfer in progress
// - count zero flag when counter ends
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
`define FIFO_DEPTH 2
`define FIFO_PTR_W 1
`define BYTE_W 8
`define DUMMY_BYTE 8'h00
`define MODE_FULL 2'h0
`define MODE_RX_ONLY 2'h1
`define MODE_TX_ONLY 2'h2
`define ST_IDLE 2'h0
`define ST_FIRST 2'h1
`define ST_SECOND 2'h2
`endif

/* design/byte_fifo.v */
// two-entry byte FIFO used for both data paths
`timescale 1ns/100ps
`include "spi_port_map.vh"
module byte_fifo (
   input wire clk_sys,
   input wire rstn,
   input wire flush,
   input wire [7:0] inData,
   input wire inValid,
   output wire inReady,
   output reg [7:0] outData,
   output wire outValid,
   input wire outReady
);
   reg [7:0] mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_PTR_W-1:0] wrPtr;
   reg [`FIFO_PTR_W-1:0] rdPtr;
   reg [1:0] count;
   wire doWrite;
   wire doRead;
   assign inReady = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign doWrite = inValid & inReady;
   assign doRead = outValid & outReady;
   always @* begin
      outData = mem[rdPtr];
   end
   always @(posedge clk_sys) begin
      if (doWrite & ~flush) begin
         mem[wrPtr] <= inData;
      end
   end
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= 1'h0;
         rdPtr <= 1'h0;
         count <= 2'h0;
      end else if (flush) begin
         wrPtr <= 1'h0;
         rdPtr <= 1'h0;
         count <= 2'h0;
      end else begin
         if (doWrite) begin
            wrPtr <= wrPtr + 1'h1;
         end
         if (doRead) begin
            rdPtr <= rdPtr + 1'h1;
         end
         if (doWrite & ~doRead) begin
            count <= count + 2'h1;
         end else if (doRead & ~doWrite) begin
            count <= count - 2'h1;
         end
      end
   end
endmodule

/* design/spi_port.v */
// master/slave serial peripheral port with byte FIFOs
`timescale 1ns/100ps
`include "spi_port_map.vh"
module spi_port (
   input wire clk_sys,
   input wire rstn,
   input wire enable,
   input wire masterMode,
   input wire clockIdleHigh,
   input wire outOnSecondEdge,
   input wire sampleAtEnd,
   input wire invertDataIn,
   input wire invertDataOut,
   input wire selectActiveHigh,
   input wire lsbFirst,
   input wire selectAlwaysDrive,
   input wire [1:0] duplexMode,
   input wire countedMode,
   input wire [15:0] transferCount,
   input wire countLoad,
   input wire [3:0] segmentWidth,
   input wire [7:0] serialRateDivider,
   input wire receiveKeepEnable,
   input wire transmitKeepEnable,
   input wire pinDirectionControl,
   input wire [7:0] txData,
   input wire txValid,
   output wire txReady,
   output wire [7:0] rxData,
   output wire rxValid,
   input wire rxReady,
   input wire sckIn,
   output reg sckOut,
   output reg sckOe,
   input wire sdi,
   output reg sdo,
   output reg sdoOe,
   input wire ssIn,
   output reg ssOut,
   output reg ssOe,
   output wire serialTxInternal,
   output reg busy,
   output reg countZeroFlag,
   input wire countZeroClear
);
   // pin synchronisers, first stage read only by second
   reg sckMeta, sckSync, sckPrev;
   reg sdiMeta, sdiSync;
   reg ssMeta, ssSync;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sckMeta <= 1'b0;
         sckSync <= 1'b0;
         sckPrev <= 1'b0;
         sdiMeta <= 1'b0;
         sdiSync <= 1'b0;
         ssMeta <= 1'b0;
         ssSync <= 1'b0;
      end else begin
         sckMeta <= sckIn;
         sckSync <= sckMeta;
         sckPrev <= sckSync;
         sdiMeta <= sdi;
         sdiSync <= sdiMeta;
         ssMeta <= ssIn;
         ssSync <= ssMeta;
      end
   end

   wire dataIn = sdiSync ^ invertDataIn;
   wire slaveSelected = enable & ~masterMode &
      (ssSync == selectActiveHigh);
   wire [3:0] width = (segmentWidth == 4'h0 || segmentWidth > 4'h8) ?
      4'h8 : segmentWidth;
   wire rxKeep = receiveKeepEnable & (duplexMode != `MODE_TX_ONLY);
   wire txKeep = transmitKeepEnable & (duplexMode != `MODE_RX_ONLY);

   // FIFOs
   wire [7:0] txHead;
   wire txAvail;
   reg txPop;
   reg [7:0] rxPush;
   reg rxPushValid;
   wire rxRoom;
   byte_fifo txFifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .flush(~enable),
      .inData(txData),
      .inValid(txValid),
      .inReady(txReady),
      .outData(txHead),
      .outValid(txAvail),
      .outReady(txPop)
   );
   byte_fifo rxFifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .flush(~enable),
      .inData(rxPush),
      .inValid(rxPushValid),
      .inReady(rxRoom),
      .outData(rxData),
      .outValid(rxValid),
      .outReady(rxReady)
   );

   // master rate divider: one enable pulse per half period
   reg [7:0] divCount;
   wire halfTick = (divCount == serialRateDivider);
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         divCount <= 8'h00;
      end else if (!enable || !busy || halfTick) begin
         divCount <= 8'h00;
      end else begin
         divCount <= divCount + 8'h01;
      end
   end

   // slave edges seen on the synchronised clock, normalised to idle
   wire sckLevel = sckSync ^ clockIdleHigh;
   wire sckPrevLevel = sckPrev ^ clockIdleHigh;
   wire slaveLead = slaveSelected & sckLevel & ~sckPrevLevel;
   wire slaveTrail = slaveSelected & ~sckLevel & sckPrevLevel;

   reg [1:0] state;
   reg [7:0] shiftOut;
   reg [7:0] shiftIn;
   reg [3:0] bitCount;
   reg [15:0] remaining;
   reg sampled;
   reg outBit;
   reg haveWord;

   // master: available word, or dummy or receive-only generation
   wire countLeft = (remaining != 16'h0000);
   wire masterWork = txKeep ? txAvail :
      (countedMode ? countLeft : rxRoom | ~rxKeep);
   wire needStall = rxKeep & ~rxRoom;
   wire [7:0] loadByte = txKeep ? txHead : `DUMMY_BYTE;
   wire leadEdge = masterMode ? (state == `ST_FIRST && halfTick) :
      slaveLead;
   wire trailEdge = masterMode ? (state == `ST_SECOND && halfTick) :
      slaveTrail;
   // launch happens on lead edge when outputting on second edge
   wire shiftEdge = outOnSecondEdge ? leadEdge : trailEdge;
   wire captEdge = outOnSecondEdge ? trailEdge : leadEdge;
   wire msbBit = lsbFirst ? shiftOut[0] : shiftOut[7];
   // second-edge output: the last capture closes the segment
   wire lastEdge = outOnSecondEdge ? captEdge : shiftEdge;
   wire [7:0] withData = lsbFirst ? {dataIn, shiftIn[7:1]} :
      {shiftIn[6:0], dataIn};
   wire [7:0] withSampled = lsbFirst ? {sampled, shiftIn[7:1]} :
      {shiftIn[6:0], sampled};

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= `ST_IDLE;
         shiftOut <= 8'h00;
         shiftIn <= 8'h00;
         bitCount <= 4'h0;
         remaining <= 16'h0000;
         sampled <= 1'b0;
         outBit <= 1'b0;
         haveWord <= 1'b0;
         txPop <= 1'b0;
         rxPush <= 8'h00;
         rxPushValid <= 1'b0;
         busy <= 1'b0;
         countZeroFlag <= 1'b0;
      end else begin
         txPop <= 1'b0;
         rxPushValid <= 1'b0;
         if (countZeroClear) begin
            countZeroFlag <= 1'b0;
         end
         if (!enable) begin
            state <= `ST_IDLE;
            bitCount <= 4'h0;
            haveWord <= 1'b0;
            busy <= 1'b0;
            if (countLoad) begin
               remaining <= transferCount;
            end
         end else begin
            if (countLoad && !busy) begin
               remaining <= transferCount;
            end
            // load a new word when none is held
            if (!haveWord && (masterMode ? masterWork && !needStall &&
                  state == `ST_IDLE : slaveSelected)) begin
               shiftOut <= loadByte;
               outBit <= lsbFirst ? loadByte[0] : loadByte[7];
               txPop <= txKeep & txAvail;
               haveWord <= 1'b1;
               bitCount <= 4'h0;
               if (masterMode) begin
                  state <= `ST_FIRST;
                  busy <= 1'b1;
                  if (countedMode && duplexMode == `MODE_TX_ONLY) begin
                     remaining <= remaining - 16'h0001;
                  end
               end
            end
            if (masterMode && state == `ST_FIRST && halfTick) begin
               state <= `ST_SECOND;
            end
            if (masterMode && state == `ST_SECOND && halfTick) begin
               state <= `ST_FIRST;
            end
            // sample in middle or at end of the bit time
            if (haveWord && captEdge) begin
               sampled <= dataIn;
               if (!sampleAtEnd) begin
                  shiftIn <= lsbFirst ? {dataIn, shiftIn[7:1]} :
                     {shiftIn[6:0], dataIn};
               end
            end
            if (haveWord && shiftEdge) begin
               if (sampleAtEnd) begin
                  shiftIn <= lsbFirst ? {sampled, shiftIn[7:1]} :
                     {shiftIn[6:0], sampled};
               end
               shiftOut <= lsbFirst ? {1'b0, shiftOut[7:1]} :
                  {shiftOut[6:0], 1'b0};
               outBit <= outOnSecondEdge ? msbBit :
                  (lsbFirst ? shiftOut[1] : shiftOut[6]);
            end
            if (haveWord && lastEdge) begin
               if (bitCount + 4'h1 == width) begin
                  haveWord <= 1'b0;
                  if (rxKeep) begin
                     rxPush <= outOnSecondEdge ? withData :
                        (sampleAtEnd ? withSampled : shiftIn);
                     rxPushValid <= 1'b1;
                  end
                  if (masterMode) begin
                     state <= `ST_IDLE;
                     busy <= 1'b0;
                     if (countedMode && duplexMode == `MODE_TX_ONLY &&
                           remaining == 16'h0000) begin
                        countZeroFlag <= 1'b1;
                     end
                  end
               end else begin
                  bitCount <= bitCount + 4'h1;
               end
            end
            if (!masterMode && !slaveSelected) begin
               haveWord <= 1'b0;
               bitCount <= 4'h0;
            end
         end
      end
   end

   wire txBit = (haveWord ? outBit : 1'b0) ^ invertDataOut;
   assign serialTxInternal = txBit;
   // every segment opens with an idle-level half period
   wire masterClkHigh = (state == `ST_SECOND);

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sckOut <= 1'b0;
         sckOe <= 1'b0;
         sdo <= 1'b0;
         sdoOe <= 1'b0;
         ssOut <= 1'b0;
         ssOe <= 1'b0;
      end else begin
         sckOe <= enable & masterMode;
         sckOut <= clockIdleHigh ^ (busy & masterClkHigh &
            (state != `ST_IDLE));
         ssOe <= enable & masterMode;
         ssOut <= (busy | selectAlwaysDrive) ? selectActiveHigh :
            ~selectActiveHigh;
         sdo <= txBit;
         sdoOe <= enable & (masterMode | slaveSelected |
            pinDirectionControl);
      end
   end
endmodule

/* test/spi_port_assertions.sv */
// concurrent checks on the serial port pins and status
`timescale 1ns/100ps
`include "spi_port_map.vh"
module spi_port_assertions (
   input logic clk_sys,
   input logic rstn,
   input logic enable,
   input logic masterMode,
   input logic clockIdleHigh,
   input logic selectActiveHigh,
   input logic selectAlwaysDrive,
   input logic pinDirectionControl,
   input logic receiveKeepEnable,
   input logic [1:0] duplexMode,
   input logic [3:0] segmentWidth,
   input logic [7:0] serialRateDivider,
   input logic countZeroClear,
   input logic ssIn,
   input logic sckOut,
   input logic sckOe,
   input logic sdoOe,
   input logic ssOut,
   input logic rxValid,
   input logic busy,
   input logic countZeroFlag
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // only the fastest byte segment is timed, within a window of cycles
   sequence fastSeg;
      $rose(busy) && masterMode && serialRateDivider == 8'h00 &&
         segmentWidth == 4'h8;
   endsequence
   sequence segRun;
      busy [*8] ##[6:10] !busy;
   endsequence
   sequence quietSlave;
      (!masterMode && enable && !pinDirectionControl &&
         ssIn != selectActiveHigh) [*4];
   endsequence
   seg_length_a: assert property (fastSeg |-> segRun)
      else $error("segment length wrong");
   clock_stop_a: assert property ($fell(busy) && masterMode && enable
      |-> ##[0:3] sckOut == clockIdleHigh) else $error("clock not idle");
   select_release_a: assert property ($fell(busy) && masterMode
      && !selectAlwaysDrive |-> ##[0:4] ssOut != selectActiveHigh)
      else $error("select not released");
   master_drive_a: assert property (enable && masterMode && busy &&
      $past(busy) |-> sckOe) else $error("master not driving clock");
   slave_input_a: assert property (!masterMode && !$past(masterMode)
      |-> !sckOe) else $error("slave drives clock");
   disable_abort_a: assert property (!enable |=> !busy && !rxValid)
      else $error("disable did not abort");
   forced_drive_a: assert property (enable && pinDirectionControl
      |=> sdoOe) else $error("data pin not forced");
   slave_quiet_a: assert property (quietSlave |-> !sdoOe && !busy)
      else $error("unselected slave active");
   rx_stored_a: assert property ($fell(busy) && enable &&
      receiveKeepEnable && duplexMode != `MODE_TX_ONLY |-> ##[0:3] rxValid)
      else $error("byte not stored");
   discard_a: assert property (enable && !rxValid && (!receiveKeepEnable
      || duplexMode == `MODE_TX_ONLY) |=> !rxValid)
      else $error("data kept");
   flag_hold_a: assert property (countZeroFlag && !countZeroClear
      |=> countZeroFlag) else $error("flag lost");
endmodule
bind spi_port spi_port_assertions u_chk (.*);

/* test/spi_slave_model.sv */
// behavioural slave device facing the port in master role
`timescale 1ns/100ps
module spi_slave_model #(parameter logic [7:0] REPLY = 8'h96) (
   input wire logic sck,
   input wire logic sel,
   input wire logic idleHigh,
   input wire logic selHigh,
   input wire logic mosi,
   output logic miso,
   output logic [7:0] cap
);
   logic [7:0] sh = 8'h00;
   initial miso = 1'b0;
   initial cap = 8'h00;
   always @(sel) begin
      if (sel == selHigh) begin
         sh = REPLY;
         miso = REPLY[7];
         cap = 8'h00;
      end else
         miso = ~miso;
   end
   // first-edge capture, second-edge change
   always @(sck) begin
      if (sel == selHigh && sck != idleHigh) begin
         cap = {cap[6:0], mosi};
      end else if (sel == selHigh) begin
         sh = {sh[6:0], 1'b0};
         miso = sh[7];
      end
   end
endmodule

/* test/tb.sv */
// self-checking bench for the serial port in master and slave roles
`timescale 1ns/100ps
module tb;
   logic clk_sys = 0, rstn = 0, enable = 0, masterMode = 1, busy;
   logic clockIdleHigh = 0, outOnSecondEdge = 0, sampleAtEnd = 0;
   logic invertDataIn = 0, invertDataOut = 0, selectActiveHigh = 0;
   logic lsbFirst = 0, selectAlwaysDrive = 0, countedMode = 0;
   logic countLoad = 0, receiveKeepEnable = 1, transmitKeepEnable = 1;
   logic pinDirectionControl = 0, txValid = 0, rxReady = 0, sckIn = 0;
   logic ssIn = 0, countZeroClear = 0, benchSdi = 0, sdi, miso;
   logic [1:0] duplexMode = 0;
   logic [3:0] segmentWidth = 4'h8;
   logic [7:0] serialRateDivider = 8'h03, txData = 8'h00, rxData, cap;
   logic [15:0] transferCount = 16'h0000;
   logic txReady, rxValid, sckOut, sckOe, sdo, sdoOe, ssOut, ssOe;
   logic serialTxInternal, countZeroFlag;
   integer n_fail = 0, num_checks = 0, cyc = 0, r, i;
   typedef struct packed {logic [1:0] m; logic l, k; logic [3:0] w;
      logic [7:0] d, t, c, x;} row_t;
   row_t rows [0:4];
   assign sdi = masterMode ? miso : benchSdi;
   spi_port u_dut (.*);
   // single slave on the select line
   spi_slave_model #(.REPLY(8'h96)) u_slave (.sck(sckOut), .sel(ssOut),
      .idleHigh(clockIdleHigh), .selHigh(selectActiveHigh), .mosi(sdo),
      .miso(miso), .cap(cap));
   always #2.5 clk_sys = ~clk_sys;
   task check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   // valid stays up so words can follow back to back
   task send(input logic [7:0] d);
      txData <= d;
      txValid <= 1'b1;
      do @(negedge clk_sys); while (txReady !== 1'b1);
      @(posedge clk_sys);
   endtask
   task seg;
      for (i = 0; i < 50 && busy !== 1'b1; i = i + 1)
         @(negedge clk_sys);
      for (i = 0; i < 900 && busy !== 1'b0; i = i + 1)
         @(negedge clk_sys);
      tick(6);
   endtask
   task pop(input logic [7:0] exp);
      @(negedge clk_sys);
      check(rxValid, 1'b1);
      check(rxData, exp);
      @(posedge clk_sys);
      rxReady <= 1'b1;
      @(posedge clk_sys);
      rxReady <= 1'b0;
   endtask
   // config only moves while disabled
   task cfg(input row_t x);
      enable <= 1'b0;
      tick(2);
      {duplexMode, lsbFirst, receiveKeepEnable} <= {x.m, x.l, x.k};
      {segmentWidth, serialRateDivider} <= {x.w, x.d};
      tick(2);
      enable <= 1'b1;
      tick(2);
   endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   initial begin
      rows[0] = {2'h0, 1'b0, 1'b1, 4'h8, 8'h03, 8'ha5, 8'ha5, 8'h96};
      rows[1] = {2'h0, 1'b1, 1'b1, 4'h8, 8'h03, 8'h01, 8'h80, 8'h69};
      rows[2] = {2'h0, 1'b0, 1'b0, 4'h3, 8'h03, 8'ha0, 8'h05, 8'h00};
      rows[3] = {2'h2, 1'b0, 1'b0, 4'h8, 8'h00, 8'h0f, 8'h0f, 8'h00};
      rows[4] = {2'h0, 1'b0, 1'b0, 4'h8, 8'h03, 8'h3c, 8'h3c, 8'h00};
      tick(2);
      @(negedge clk_sys);
      check({busy, rxValid, countZeroFlag}, 8'h00);
      @(posedge clk_sys);
      rstn <= 1'b1;
      for (r = 0; r < 5; r = r + 1) begin
         cfg(rows[r]);
         send(rows[r].t);
         txValid <= 1'b0;
         seg;
         check(cap, rows[r].c);
         if (rows[r].k)
            pop(rows[r].x);
         else
            check(rxValid, 1'b0);
      end
      cfg(rows[0]);
      send(8'h11);
      send(8'h22);
      send(8'h33);
      txValid <= 1'b0;
      @(negedge clk_sys);
      check(txReady, 1'b0);
      tick(10);
      enable <= 1'b0;
      tick(3);
      enable <= 1'b1;
      tick(4);
      check({busy, rxValid}, 8'h00);
      countedMode <= 1'b1;
      transferCount <= 16'h0002;
      cfg(rows[3]);
      countLoad <= 1'b1;
      tick(1);
      countLoad <= 1'b0;
      send(8'ha1);
      send(8'ha2);
      txValid <= 1'b0;
      for (i = 0; i < 300 && countZeroFlag !== 1'b1; i = i + 1)
         @(negedge clk_sys);
      check(countZeroFlag, 1'b1);
      @(posedge clk_sys);
      countZeroClear <= 1'b1;
      tick(1);
      countZeroClear <= 1'b0;
      tick(2);
      check(countZeroFlag, 1'b0);
      {countedMode, masterMode, selectActiveHigh} <= 3'b001;
      cfg(rows[0]);
      tick(8);
      ssIn <= 1'b1;
      tick(16);
      for (r = 7; r >= 0; r = r - 1) begin
         sckIn <= 1'b1;
         benchSdi <= r[0] ^ (r > 3) ? 1'b0 : 1'b1;
         tick(16);
         sckIn <= 1'b0;
         tick(16);
      end
      ssIn <= 1'b0;
      tick(8);
      pop(8'ha5);
      check(sdoOe, 1'b0);
      pinDirectionControl <= 1'b1;
      cfg(rows[0]);
      check(sdoOe, 1'b1);
      final_report;
   end
endmodule
